// *** hdl/sws_pkg.sv ***
`default_nettype none
package sws_pkg;
  localparam int CLK_MHZ = 40;
  localparam int CNT_W = 15;
  localparam logic [14:0] CNT_MAX = 15'h7FFF;
  // x^8 + x^5 + x^4 + 1, bit-reversed for lsb-first shifting
  localparam logic [7:0] CRC_POLY = 8'h8C;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;

  // least times round up
  function automatic int cyc_up(input int ns);
    int v;
    v = (ns * CLK_MHZ + 999) / 1000;
    return (v < 1) ? 1 : v;
  endfunction

  // longest times round down
  function automatic int cyc_dn(input int ns);
    int v;
    v = (ns * CLK_MHZ) / 1000;
    return (v < 1) ? 1 : v;
  endfunction

  localparam int T_FILT_STD_NS = 250;
  localparam int T_FILT_OD_NS = 25;
  localparam int T_SAMP_STD_NS = 30000;
  localparam int T_SAMP_OD_NS = 4000;
  localparam int T_HOLD_STD_NS = 30000;
  localparam int T_HOLD_OD_NS = 3000;
  localparam int T_PW_STD_NS = 15000;
  localparam int T_PW_OD_NS = 2000;
  localparam int T_PL_STD_NS = 60000;
  localparam int T_PL_OD_NS = 8000;
  localparam int T_HOF_STD_NS = 500;
  localparam int T_HOF_OD_NS = 250;
  localparam int T_RDET_STD_NS = 120000;
  localparam int T_RDET_OD_NS = 16000;
  localparam int T_RLONG_NS = 480000;
  localparam int T_ODKEEP_NS = 80000;

  localparam logic [14:0] C_FILT_STD = 15'(cyc_up(T_FILT_STD_NS));
  localparam logic [14:0] C_FILT_OD = 15'(cyc_up(T_FILT_OD_NS));
  localparam logic [14:0] C_SAMP_STD = 15'(cyc_up(T_SAMP_STD_NS));
  localparam logic [14:0] C_SAMP_OD = 15'(cyc_up(T_SAMP_OD_NS));
  localparam logic [14:0] C_HOLD_STD = 15'(cyc_dn(T_HOLD_STD_NS));
  localparam logic [14:0] C_HOLD_OD = 15'(cyc_dn(T_HOLD_OD_NS));
  localparam logic [14:0] C_PW_STD = 15'(cyc_up(T_PW_STD_NS));
  localparam logic [14:0] C_PW_OD = 15'(cyc_up(T_PW_OD_NS));
  localparam logic [14:0] C_PL_STD = 15'(cyc_up(T_PL_STD_NS));
  localparam logic [14:0] C_PL_OD = 15'(cyc_up(T_PL_OD_NS));
  localparam logic [14:0] C_HOF_STD = 15'(cyc_up(T_HOF_STD_NS));
  localparam logic [14:0] C_HOF_OD = 15'(cyc_up(T_HOF_OD_NS));
  localparam logic [14:0] C_RDET_OD = 15'(cyc_up(T_RDET_OD_NS));
  localparam logic [14:0] C_ODKEEP = 15'(cyc_dn(T_ODKEEP_NS));

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SLOT = 3'h1,
    S_HOLD = 3'h3,
    S_PWAIT = 3'h5,
    S_PLOW = 3'h7
  } sws_state_t;
endpackage
`default_nettype wire

// *** hdl/sws_crc8.sv ***
`timescale 1ns/1ps
`default_nettype none
module sws_crc8
  import sws_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_n, // sync reset, active low
  input wire logic clr, // restart the sum
  input wire logic en, // fold one bit in
  input wire logic din, // bit, lsb first
  output logic [7:0] crc // running sum
);
  typedef struct packed {
    logic [7:0] crc;
  } sws_crc_st_t;

  sws_crc_st_t r;
  sws_crc_st_t n;
  logic [7:0] base;

  always_comb
  begin
    base = clr ? 8'h00 : r.crc;
    n.crc = base;
    // a clear in the same cycle as a bit folds that bit into a fresh sum
    if (en)
      n.crc = {1'b0, base[7:1]} ^ (((base[0] ^ din) == 1'b1) ? CRC_POLY : 8'h00);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

  assign crc = r.crc;
endmodule
`default_nettype wire

// *** hdl/sws_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module sws_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // sync reset, active low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [W-1:0] out_data // oldest word
);
  localparam int AW = $clog2(D);

  // depth must be a power of two so the pointers wrap by themselves
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sws_fifo_st_t;

  sws_fifo_st_t r;
  sws_fifo_st_t n;
  logic push;
  logic pop;

  assign in_ready = (r.cnt != (AW + 1)'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    n = r;
    if (push)
    begin
      n.mem[r.wp] = in_data;
      n.wp = r.wp + AW'(1);
    end
    if (pop)
      n.rp = r.rp + AW'(1);
    if (push && !pop)
      n.cnt = r.cnt + (AW + 1)'(1);
    else if (pop && !push)
      n.cnt = r.cnt - (AW + 1)'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end
endmodule
`default_nettype wire

// *** hdl/sws_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - only presence pulse starts a device-driven low
// - standard speed unless overdrive set; overdrive times all
// - reset low 480us or longer clears overdrive
// - overdrive kept when reset low at most 80us
// - speed after 80..480us overdrive reset undefined
// - after reset rise, wait then pull presence low
// - slot falling edge starts internal slot timer
// - recovery time needed before next slot
// - read zero pulls low until timer; one never
// - falling-edge filter at standard speed only
// - ignore low glitches during rising-edge hold-off
// - identifier crc uses x^8+x^5+x^4+1
// - identifier crc sent true, not inverted
// - speed set command enters overdrive
// - long low on idle-high line means reset
module sws_slave
  import sws_pkg::*;
#(
  parameter logic [14:0] RST_LONG_CYC = 15'(cyc_up(T_RLONG_NS)),
  parameter logic [14:0] RST_DET_STD_CYC = 15'(cyc_up(T_RDET_STD_NS))
) (
  input wire logic CORE_CLK, // core clock, 40 MHz
  input wire logic RST_N, // sync reset, active low
  input wire logic LINE_IN, // line level, 1 = high
  output logic LINE_OUT, // line drive value, always low
  output logic LINE_OE, // high while pulling the line low
  input wire logic SPEED_SET, // pulse: enter overdrive
  output logic SPEED_FLAG, // overdrive active
  output logic LINE_RESET, // pulse: reset pulse seen
  input wire logic TX_VALID, // byte offered for read slots
  output logic TX_READY, // byte can be taken
  input wire logic [7:0] TX_DATA, // byte to send, lsb first
  input wire logic TX_CRC, // send running crc instead
  input wire logic CRC_CLR, // restart running crc
  output logic [7:0] CRC_VALUE, // running crc
  output logic RX_VALID, // written byte available
  input wire logic RX_READY, // written byte taken
  output logic [7:0] RX_DATA, // written byte
  output logic RX_OVERRUN // sticky: byte lost, buffer full
);
  typedef struct packed {
    sws_state_t state;
    logic [14:0] cnt;
    logic drv;
    logic od;
    logic smp;
    logic rd;
    logic tx_act;
    logic [7:0] tx_sh;
    logic [2:0] tx_cnt;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic hold_v;
    logic [7:0] hold_d;
    logic ovr;
    logic rst_p;
  } sws_st_t;

  sws_st_t r;
  sws_st_t n;
  logic [14:0] filt_c;
  logic [14:0] samp_c;
  logic [14:0] hold_c;
  logic [14:0] pw_c;
  logic [14:0] pl_c;
  logic [14:0] hof_c;
  logic [14:0] det_c;
  logic [14:0] cnt_inc;
  logic rise;
  logic rst_ev;
  logic tx_ready;
  logic fifo_in_ready;
  logic crc_en;
  logic crc_bit;
  logic crc_clr;
  logic [7:0] crc_val;

  ////////////////////////////////////////////////////////////////////////////
  // per-speed timing
  assign filt_c = r.od ? C_FILT_OD : C_FILT_STD;
  assign samp_c = r.od ? C_SAMP_OD : C_SAMP_STD;
  assign hold_c = r.od ? C_HOLD_OD : C_HOLD_STD;
  assign pw_c = r.od ? C_PW_OD : C_PW_STD;
  assign pl_c = r.od ? C_PL_OD : C_PL_STD;
  assign hof_c = r.od ? C_HOF_OD : C_HOF_STD;
  assign det_c = r.od ? C_RDET_OD : RST_DET_STD_CYC;
  assign cnt_inc = r.cnt + 15'h0001;

  // while the device pulls low the line cannot rise, so no early slot end
  assign rise = (r.state == S_SLOT) && LINE_IN && !r.drv;
  assign rst_ev = rise && (r.cnt >= det_c);
  // a byte loaded mid-slot would change a slot already decided
  assign tx_ready = !r.tx_act && (r.state != S_SLOT);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    n = r;
    crc_en = 1'b0;
    crc_bit = 1'b0;
    crc_clr = CRC_CLR;
    n.rst_p = 1'b0;
    if (r.hold_v && fifo_in_ready)
      n.hold_v = 1'b0;
    if (TX_VALID && tx_ready)
    begin
      n.tx_act = 1'b1;
      n.tx_cnt = 3'h0;
      n.tx_sh = TX_CRC ? crc_val : TX_DATA;
    end
    case (r.state)
      S_IDLE:
      begin
        if (LINE_IN)
          n.cnt = 15'h0000;
        else if (cnt_inc >= filt_c)
        begin
          n.state = S_SLOT;
          n.cnt = filt_c;
          n.smp = 1'b1;
          n.rd = n.tx_act;
          n.drv = n.tx_act && !n.tx_sh[0];
        end
        else
          n.cnt = cnt_inc;
      end
      S_SLOT:
      begin
        n.cnt = (r.cnt == CNT_MAX) ? r.cnt : cnt_inc;
        if (r.cnt == samp_c)
          n.smp = LINE_IN;
        if (cnt_inc >= hold_c)
          n.drv = 1'b0;
        if (rise)
        begin
          n.cnt = 15'h0000;
          if (rst_ev)
          begin
            n.state = S_PWAIT;
            n.rst_p = 1'b1;
            n.tx_act = 1'b0;
            n.rx_cnt = 3'h0;
            n.ovr = 1'b0;
            crc_clr = 1'b1;
            // between the keep and long limits the speed is left as it was
            if (r.cnt >= RST_LONG_CYC)
              n.od = 1'b0;
          end
          else
          begin
            n.state = S_HOLD;
            crc_en = 1'b1;
            if (r.rd)
            begin
              crc_bit = r.tx_sh[0];
              n.tx_sh = {1'b0, r.tx_sh[7:1]};
              n.tx_cnt = r.tx_cnt + 3'h1;
              if (r.tx_cnt == 3'h7)
                n.tx_act = 1'b0;
            end
            else
            begin
              crc_bit = r.smp;
              n.rx_sh = {r.smp, r.rx_sh[7:1]};
              n.rx_cnt = r.rx_cnt + 3'h1;
              if (r.rx_cnt == 3'h7)
              begin
                // the master cannot be stalled, so a full buffer costs a byte
                if (n.hold_v)
                  n.ovr = 1'b1;
                else
                begin
                  n.hold_v = 1'b1;
                  n.hold_d = {r.smp, r.rx_sh[7:1]};
                end
              end
            end
          end
        end
      end
      S_HOLD:
      begin
        // line ignored here: swallows rising-edge glitches
        if (cnt_inc >= hof_c)
        begin
          n.state = S_IDLE;
          n.cnt = 15'h0000;
        end
        else
          n.cnt = cnt_inc;
      end
      S_PWAIT:
      begin
        if (cnt_inc >= pw_c)
        begin
          n.state = S_PLOW;
          n.cnt = 15'h0000;
          n.drv = 1'b1;
        end
        else
          n.cnt = cnt_inc;
      end
      S_PLOW:
      begin
        if (cnt_inc >= pl_c)
        begin
          n.state = S_HOLD;
          n.cnt = 15'h0000;
          n.drv = 1'b0;
        end
        else
          n.cnt = cnt_inc;
      end
      default:
      begin
        n.state = S_IDLE;
        n.cnt = 15'h0000;
        n.drv = 1'b0;
      end
    endcase
    // set after the reset clear so a coinciding command wins
    if (SPEED_SET)
      n.od = 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      r <= '0;
    else
      r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // crc and receive buffer
  sws_crc8 u_crc (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .clr(crc_clr),
    .en(crc_en),
    .din(crc_bit),
    .crc(crc_val)
  );

  sws_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .in_valid(r.hold_v),
    .in_ready(fifo_in_ready),
    .in_data(r.hold_d),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(RX_DATA)
  );

  assign LINE_OUT = 1'b0;
  assign LINE_OE = r.drv;
  assign SPEED_FLAG = r.od;
  assign LINE_RESET = r.rst_p;
  assign TX_READY = tx_ready;
  assign CRC_VALUE = crc_val;
  assign RX_OVERRUN = r.ovr;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_own_fall;
    $rose(LINE_OE) |-> ($past(r.state) == S_PWAIT) || ($past(LINE_IN) == 1'b0);
  endproperty
  a_own_fall: assert property (p_own_fall) else $error("device began a low");

  property p_long_rst;
    (rst_ev && (r.cnt >= RST_LONG_CYC) && !SPEED_SET) |=> !SPEED_FLAG;
  endproperty
  a_long_rst: assert property (p_long_rst) else $error("long reset kept overdrive");

  property p_short_rst;
    (rst_ev && r.od && (r.cnt <= C_ODKEEP)) |=> SPEED_FLAG;
  endproperty
  a_short_rst: assert property (p_short_rst) else $error("short reset left overdrive");

  property p_od_nofilt;
    (r.od && (r.state == S_IDLE) && !LINE_IN) |=> (r.state == S_SLOT);
  endproperty
  a_od_nofilt: assert property (p_od_nofilt) else $error("overdrive edge filtered");

  property p_std_filt;
    ((r.state == S_IDLE) && LINE_IN && !r.od) ##1 (!LINE_IN && !r.od) |=> (r.state == S_IDLE);
  endproperty
  a_std_filt: assert property (p_std_filt) else $error("one-cycle low took a slot");

  property p_pres_wait;
    ($rose(LINE_OE) && (r.state == S_PLOW)) |-> ($past(r.cnt) == pw_c - 15'h0001);
  endproperty
  a_pres_wait: assert property (p_pres_wait) else $error("presence wait wrong");

  property p_pres_low;
    ($fell(LINE_OE) && (r.state == S_HOLD)) |-> ($past(r.cnt) == pl_c - 15'h0001);
  endproperty
  a_pres_low: assert property (p_pres_low) else $error("presence low wrong");

  property p_read_zero;
    ($fell(LINE_OE) && (r.state == S_SLOT)) |-> ($past(r.cnt) == hold_c - 15'h0001);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("read zero release wrong");

  property p_read_one;
    ((r.state == S_SLOT) && r.rd && r.tx_sh[0]) |-> !LINE_OE;
  endproperty
  a_read_one: assert property (p_read_one) else $error("read one pulled low");

  property p_holdoff;
    $rose(r.state == S_HOLD) |-> (r.state == S_HOLD)[*8];
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("hold-off cut short");

  property p_no_rst;
    (rise && (r.cnt < det_c)) |=> ((r.state == S_HOLD) && !LINE_RESET);
  endproperty
  a_no_rst: assert property (p_no_rst) else $error("short low taken as reset");

  property p_crc_true;
    (TX_VALID && TX_READY && TX_CRC) |=> (r.tx_sh == $past(crc_val));
  endproperty
  a_crc_true: assert property (p_crc_true) else $error("crc not sent true");

  c_presence: cover property ((r.state == S_PLOW) ##1 (r.state == S_HOLD));
  c_od: cover property ($rose(SPEED_FLAG));
  c_read0: cover property ($fell(LINE_OE) && (r.state == S_SLOT));
  c_rxbyte: cover property (RX_VALID && RX_READY);
endmodule
`default_nettype wire

// *** tb/sws_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module sws_master
(
  input wire logic clk, // core clock
  input wire logic line, // resolved line level
  output logic drv // master drive, 0 pulls low
);
  // every task starts and ends 1 ns after a clock edge
  initial drv = 1'b1;
  task automatic hold_lvl(input logic v, input int n);
    drv = v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic write_bit(input logic b, input logic od);
    int lo;
    int slot;
    lo = b ? (od ? 2 : 20) : (od ? 200 : 1300);
    slot = od ? 230 : 1340;
    hold_lvl(1'b0, lo);
    hold_lvl(1'b1, slot - lo);
  endtask
  task automatic read_bit(input logic od, output logic b);
    int lo;
    int smp;
    lo = od ? 2 : 20;
    smp = od ? 60 : 600;
    hold_lvl(1'b0, lo);
    hold_lvl(1'b1, smp - lo);
    b = line;
    hold_lvl(1'b1, (od ? 230 : 1340) - smp);
  endtask
  task automatic glitch(input int n);
    hold_lvl(1'b0, n);
    hold_lvl(1'b1, 40);
  endtask
  task automatic reset_pulse(input int lo, output logic pres, output int tw, output int tl);
    hold_lvl(1'b0, lo);
    drv = 1'b1;
    // let the resolved wire follow the release before it is first looked at
    #1;
    tw = 0;
    tl = 0;
    while (line === 1'b1 && tw < 4000)
    begin
      @(posedge clk);
      #1 tw++;
    end
    pres = (line === 1'b0);
    while (line === 1'b0 && tl < 4000)
    begin
      @(posedge clk);
      #1 tl++;
    end
    repeat (40) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// *** tb/sws_slave_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sws_slave_tb
  import sws_pkg::*;
();
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic SPEED_SET = 1'b0;
  logic TX_VALID = 1'b0;
  logic [7:0] TX_DATA = 8'h00;
  logic TX_CRC = 1'b0;
  logic CRC_CLR = 1'b0;
  logic RX_READY = 1'b0;
  logic LINE_OUT, LINE_OE, SPEED_FLAG, LINE_RESET, TX_READY, RX_VALID, RX_OVERRUN;
  logic [7:0] CRC_VALUE, RX_DATA;
  wire logic m_drv;
  wire logic line;
  logic [7:0] n_rst = 8'h00;
  int fail_count = 0;
  int n_compared = 0;

  // open-drain wire: either party pulling low wins
  assign line = m_drv & !(LINE_OE & !LINE_OUT);

  // long-reset limit shortened for run time, but kept above the overdrive keep limit
  sws_slave #(.RST_LONG_CYC(15'h0CE4), .RST_DET_STD_CYC(15'h05DC)) uut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .LINE_IN(line), .LINE_OUT(LINE_OUT),
    .LINE_OE(LINE_OE), .SPEED_SET(SPEED_SET), .SPEED_FLAG(SPEED_FLAG),
    .LINE_RESET(LINE_RESET), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TX_DATA(TX_DATA), .TX_CRC(TX_CRC), .CRC_CLR(CRC_CLR), .CRC_VALUE(CRC_VALUE),
    .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA), .RX_OVERRUN(RX_OVERRUN));
  sws_master m (.clk(CORE_CLK), .line(line), .drv(m_drv));

  initial
  begin
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK)
    if (LINE_RESET === 1'b1)
      n_rst <= n_rst + 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // few cycles of slack: edge sampling in the model adds fixed offsets
  task automatic chk_rng(input int got, input int exp, input string what);
    n_compared++;
    if (got < exp - 4 || got > exp + 4)
    begin
      fail_count++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] crc_ref(input logic [7:0] c, input logic [7:0] d);
    logic fb;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[0] ^ d[i];
      c = c >> 1;
      if (fb)
        c = c ^ 8'h8C;
    end
    return c;
  endfunction
  task automatic wr_byte(input logic [7:0] v, input logic od);
    for (int i = 0; i < 8; i++)
      m.write_bit(v[i], od);
  endtask
  task automatic rd_byte(input logic od, output logic [7:0] v);
    for (int i = 0; i < 8; i++)
      m.read_bit(od, v[i]);
  endtask
  task automatic send_tx(input logic [7:0] d, input logic c);
    int n;
    TX_VALID = 1'b1;
    TX_DATA = d;
    TX_CRC = c;
    n = 0;
    while (TX_READY !== 1'b1 && n < 100)
    begin
      @(posedge CORE_CLK);
      #1 n++;
    end
    @(posedge CORE_CLK);
    #1 TX_VALID = 1'b0;
  endtask
  task automatic pop_chk(input logic [7:0] exp);
    int n;
    n = 0;
    while (RX_VALID !== 1'b1 && n < 100)
    begin
      @(posedge CORE_CLK);
      #1 n++;
    end
    chk(RX_DATA, exp, "rx byte");
    RX_READY = 1'b1;
    @(posedge CORE_CLK);
    #1 RX_READY = 1'b0;
    // one idle edge so back-to-back pops never toggle the strobe in one step
    @(posedge CORE_CLK);
    #1;
  endtask
  task automatic pulse_crc_clr();
    CRC_CLR = 1'b1;
    @(posedge CORE_CLK);
    #1 CRC_CLR = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_presence();
    logic p;
    int tw;
    int tl;
    chk({LINE_OE, TX_READY, RX_VALID, SPEED_FLAG, LINE_OUT, 3'h0}, 8'h40, "reset values");
    chk(CRC_VALUE, 8'h00, "crc reset");
    m.reset_pulse(1600, p, tw, tl);
    chk({7'h00, p}, 8'h01, "presence seen");
    chk_rng(tw, int'(C_PW_STD) + 2, "presence wait");
    chk_rng(tl, int'(C_PL_STD), "presence low");
    chk(n_rst, 8'h01, "reset pulse flag");
  endtask
  task automatic t_write_glitch_crc();
    logic [7:0] d;
    d = 8'hA5;
    pulse_crc_clr();
    for (int i = 0; i < 8; i++)
    begin
      // sub-filter dip between bits must not count as a slot
      if (i == 4)
        m.glitch(5);
      m.write_bit(d[i], 1'b0);
    end
    chk(CRC_VALUE, crc_ref(8'h00, 8'hA5), "crc after write");
    pop_chk(8'hA5);
  endtask
  task automatic t_read_crc();
    logic [7:0] v;
    send_tx(8'h00, 1'b1);
    rd_byte(1'b0, v);
    chk(v, crc_ref(8'h00, 8'hA5), "crc byte true form");
    chk(CRC_VALUE, 8'h00, "crc residue");
  endtask
  task automatic t_read_byte();
    logic [7:0] v;
    send_tx(8'h3C, 1'b0);
    rd_byte(1'b0, v);
    chk(v, 8'h3C, "read byte");
    chk({7'h00, TX_READY}, 8'h01, "tx ready again");
  endtask
  task automatic t_od_fill();
    SPEED_SET = 1'b1;
    @(posedge CORE_CLK);
    #1 SPEED_SET = 1'b0;
    @(posedge CORE_CLK);
    #1 chk({7'h00, SPEED_FLAG}, 8'h01, "overdrive set");
    // eight in the buffer, one held, the tenth is lost
    for (int i = 0; i < 10; i++)
      wr_byte(8'h10 + 8'(i), 1'b1);
    chk({7'h00, RX_OVERRUN}, 8'h01, "overrun");
    for (int i = 0; i < 9; i++)
      pop_chk(8'h10 + 8'(i));
    chk({7'h00, RX_VALID}, 8'h00, "drained");
  endtask
  task automatic t_od_resets();
    logic p;
    int tw;
    int tl;
    m.reset_pulse(1000, p, tw, tl);
    chk({6'h00, SPEED_FLAG, p}, 8'h03, "short reset keeps od");
    chk_rng(tw, int'(C_PW_OD) + 2, "od presence wait");
    chk_rng(tl, int'(C_PL_OD), "od presence low");
    chk({7'h00, RX_OVERRUN}, 8'h00, "overrun cleared");
    m.reset_pulse(3400, p, tw, tl);
    chk({6'h00, SPEED_FLAG, p}, 8'h01, "long reset clears od");
    chk(n_rst, 8'h03, "reset pulse count");
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge CORE_CLK);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    #1 RST_N = 1'b1;
    @(posedge CORE_CLK);
    #1;
    t_reset_presence();
    t_write_glitch_crc();
    t_read_crc();
    t_read_byte();
    t_od_fill();
    t_od_resets();
    finish_test();
  end
endmodule
`default_nettype wire
